/* src/vssp_pkg.sv */
// Purpose: Shared constants and types of the voice slot serial port.
// Assumes: A 20 MHz system clock and 32-bit APB register access.
// Notes: Each register takes one aligned word; unused bits read as zero.
package vssp_pkg;
    // System clock rate in kHz, used by the bit clock generator.
    localparam int unsigned CLK_KHZ = 20000;
    // Number of voice channels carried at once.
    localparam int NCH = 3;
    // Bits in one slot word and significant bits of a narrow sample.
    localparam int SLOT_BITS = 16;
    localparam int SAMPLE_BITS = 13;
    // Width of the long frame sync pulse in bit periods.
    localparam int LONG_SYNC_BITS = 3;
    // Size of the transport buffer in bytes, reported in the status word.
    localparam logic [10:0] BUF_BYTES = 11'h410;
    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLOT = 8'h04;
    localparam logic [7:0] ADDR_TX0 = 8'h08;
    localparam logic [7:0] ADDR_RX0 = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h20;
    // Bit step between the channels' slot fields in the slot register; channel i starts at i times this.
    localparam int SLOT_FIELD_STEP = 8;
    // Reset values.
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [4:0] MAP_RESET = 5'h00;
    localparam logic [15:0] TX_RESET = 16'h0000;

    // Frame rate selection.
    typedef enum logic [1:0] {
        FS_8K = 2'b00,
        FS_16K = 2'b01,
        FS_4K = 2'b10
    } vssp_fs_t;

    // Fill of the three spare bits on transmission.
    typedef enum logic [1:0] {
        FILL_ZERO = 2'b00,
        FILL_ONE = 2'b01,
        FILL_SIGN = 2'b10,
        FILL_PROG = 2'b11
    } vssp_fill_t;

    // Configuration word, the low half of the control register.
    typedef struct packed {
        logic [2:0] fill_val;
        vssp_fill_t fill;
        logic full16;
        logic lsb_first;
        logic right_just;
        logic [2:0] rate_sel;
        vssp_fs_t fs;
        logic long_sync;
        logic master;
        logic enable;
    } vssp_cfg_t;

    // One channel's slot assignment.
    typedef struct packed {
        logic en;
        logic [3:0] slot;
    } vssp_map_t;

    // Link pins that arrive from outside the clock domain.
    typedef struct packed {
        logic bclk;
        logic sync;
        logic din;
    } vssp_pins_t;
endpackage

/* src/vssp_sync2.sv */
// Purpose: Two flip-flop synchroniser for link pins.
// Assumes: Inputs are asynchronous to i_clock.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ns
module vssp_sync2 #(
    parameter int W = 3
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta; // First stage, may go metastable.

    // Both stages reset to zero; the pins are idle low.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

/* src/vssp_bclk_gen.sv */
// Purpose: Master bit clock from the system clock by phase accumulation.
// Assumes: Rate select 0 to 4 stands for 128 to 2048 kHz.
// Notes: Edges jitter by one system clock; the mean rate is exact.
`timescale 1ns/1ns
module vssp_bclk_gen
    import vssp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [2:0] i_rate_sel,
    output logic o_bclk,
    output logic o_rise,
    output logic o_fall
);
    logic [14:0] acc; // Phase accumulator, below CLK_KHZ.
    logic [14:0] step; // Twice the bit clock rate in kHz.
    logic [15:0] sum;

    // Each overflow of CLK_KHZ is one half period of the bit clock.
    assign step = 15'h0100 << i_rate_sel;
    assign sum = {1'b0, acc} + {1'b0, step};

    // Toggle the clock and pulse the matching edge strobe.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc <= '0;
            o_bclk <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else if (!i_run) begin
            acc <= '0;
            o_bclk <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else if (sum >= 16'(CLK_KHZ)) begin
            acc <= 15'(sum - 16'(CLK_KHZ));
            o_bclk <= ~o_bclk;
            o_rise <= ~o_bclk;
            o_fall <= o_bclk;
        end else begin
            acc <= sum[14:0];
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end
    end
endmodule

/* src/vssp_core.sv */
// Purpose: Time-slotted voice serial port with an APB register file.
// Assumes: Link pins are asynchronous and pass a two-stage synchroniser.
// Notes: Pin outputs lag their bit clock edge by a few system clocks.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Function
// - Master drives clock and sync, slave receives
// - Three channels, each in any of slots 0 to 15
// - 8 kHz: slots follow interface rate
// - 16 kHz: slots follow interface rate
// - Transmit and receive share one slot
// - Data output off on unassigned slots
// - Release output after last-bit falling edge
// - Transparent wideband: 4 kHz sync, 16 bits
// - Codec mode carries 16-bit samples at 16 kHz
// - Short and long sync, master or slave
// - Short sync: one-bit high pulse per frame
// - Slave short sync: first bit next rise
// - Long sync: three bits from slot zero
// - Thirteen sample bits, configurable place and order
// - Spare bits ignored in, filled out
// - Reset format: left justified, MSB first
// - Transport buffer holds 1040 bytes
module vssp_core
    import vssp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire vssp_pkg::vssp_pins_t i_pins,
    output logic o_bclk,
    output logic o_bclk_oe,
    output logic o_sync,
    output logic o_sync_oe,
    output logic o_dout,
    output logic o_dout_oe
);
    import vssp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and link state.
    vssp_cfg_t cfg; // Control register.
    vssp_map_t chmap [NCH]; // Slot assignment per channel.
    logic [15:0] tx_data [NCH]; // Sample to send per channel.
    logic [15:0] rx_data [NCH]; // Last sample received per channel.
    logic [15:0] frame_cnt; // Frames seen since enable.
    logic cfg_written; // Control written since reset.
    vssp_pins_t pins_s; // Synchronised pins.
    logic bclk_prev; // Last synchronised slave clock level.
    logic sync_prev; // Sync level at the previous falling edge.
    logic slave_lock; // Slave has seen a frame sync since enable.
    logic gen_bclk, gen_rise, gen_fall;
    logic rise_evt, fall_evt; // One-cycle bit clock edge strobes.
    logic [8:0] bit_cnt; // Bit position within the frame.
    logic [8:0] next_cnt;
    logic [8:0] frame_last;
    logic [9:0] frame_bits;
    logic [NCH-1:0] hit_next, hit_cur;
    logic [1:0] ch_next; // Channel driving the coming bit.
    logic [15:0] tx_word;
    logic [15:0] rx_shift, next_shift;
    logic [3:0] bit_pos;
    logic run_master, run_slave;
    logic wr_en, rd_en;
    logic [31:0] rd_data;
    logic addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and bit clock source.
    vssp_sync2 #(.W(3)) u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async(i_pins),
        .o_sync(pins_s)
    );

    assign run_master = cfg.enable & cfg.master;
    assign run_slave = cfg.enable & ~cfg.master;

    // Clock rate in kHz equals the selected interface rate.
    vssp_bclk_gen u_bclk (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_run(run_master),
        .i_rate_sel(cfg.rate_sel),
        .o_bclk(gen_bclk),
        .o_rise(gen_rise),
        .o_fall(gen_fall)
    );

    // Slave edges are found from the synchronised clock pin.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bclk_prev <= 1'b0;
        end else begin
            bclk_prev <= pins_s.bclk;
        end
    end

    // Edge strobes come from whichever side owns the clock.
    assign rise_evt = run_master ? gen_rise : (run_slave & pins_s.bclk & ~bclk_prev);
    assign fall_evt = run_master ? gen_fall : (run_slave & ~pins_s.bclk & bclk_prev);

    // Clock and sync pins are driven only as master.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bclk_oe <= 1'b0;
            o_sync_oe <= 1'b0;
        end else begin
            o_bclk_oe <= run_master;
            o_sync_oe <= run_master;
        end
    end
    assign o_bclk = gen_bclk;

    ////////////////////////////////////////////////////////////////////////
    // Frame geometry: bits per frame is rate over frame rate.
    always_comb begin
        unique case (cfg.fs)
            FS_16K: frame_bits = 10'h008 << cfg.rate_sel;
            FS_4K: frame_bits = 10'h020 << cfg.rate_sel;
            default: frame_bits = 10'h010 << cfg.rate_sel;
        endcase
    end
    assign frame_last = 9'(frame_bits - 10'h001);
    assign next_cnt = (bit_cnt >= frame_last) ? 9'h000 : 9'(bit_cnt + 9'h001);
    assign bit_pos = bit_cnt[3:0];

    // The bit counter steps on each rise; a slave realigns on sync.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt <= '0;
            sync_prev <= 1'b0;
            frame_cnt <= '0;
        end else if (!cfg.enable) begin
            bit_cnt <= '0;
            sync_prev <= 1'b0;
            frame_cnt <= '0;
        end else if (rise_evt) begin
            bit_cnt <= next_cnt;
            if (next_cnt == 9'h000) begin
                frame_cnt <= frame_cnt + 16'h0001;
            end
        end else if (fall_evt) begin
            sync_prev <= pins_s.sync;
            if (run_slave && pins_s.sync && !sync_prev) begin
                // Short sync: the next rise starts bit zero.
                // Long sync: this bit already is bit zero; the first frame
                // after lock-in loses its opening bit.
                if (cfg.long_sync) begin
                    bit_cnt <= '0;
                end else begin
                    bit_cnt <= frame_last;
                end
            end
        end
    end

    // Master sync: short marks the bit before slot zero, long bits 0..2.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sync <= 1'b0;
        end else if (!run_master) begin
            o_sync <= 1'b0;
        end else if (rise_evt) begin
            if (cfg.long_sync) begin
                o_sync <= (next_cnt < 9'(LONG_SYNC_BITS));
            end else begin
                o_sync <= (next_cnt == frame_last);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot matching, the same slot serving both directions.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            assign hit_next[gi] = chmap[gi].en && ({1'b0, chmap[gi].slot} == next_cnt[8:4]);
            assign hit_cur[gi] = chmap[gi].en && ({1'b0, chmap[gi].slot} == bit_cnt[8:4]);

            // A finished word is unpacked into its channel.
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    rx_data[gi] <= '0;
                end else if (fall_evt && hit_cur[gi] && bit_pos == 4'hf) begin
                    if (cfg.full16) begin
                        rx_data[gi] <= next_shift;
                    end else if (cfg.right_just) begin
                        rx_data[gi] <= {{3{next_shift[12]}}, next_shift[12:0]};
                    end else begin
                        rx_data[gi] <= {{3{next_shift[15]}}, next_shift[15:3]};
                    end
                end
            end
        end
    endgenerate

    // Lowest channel wins if two share a slot.
    always_comb begin
        ch_next = 2'd0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (hit_next[i]) begin
                ch_next = 2'(i);
            end
        end
    end

    // Build the outgoing word: sample placement and spare-bit fill.
    always_comb begin
        logic [2:0] fill_bits;
        logic [12:0] smp;
        fill_bits = 3'h0;
        smp = tx_data[ch_next][12:0];
        unique case (cfg.fill)
            FILL_ONE: fill_bits = 3'h7;
            FILL_SIGN: fill_bits = {3{smp[12]}};
            FILL_PROG: fill_bits = cfg.fill_val;
            default: fill_bits = 3'h0;
        endcase
        if (cfg.full16) begin
            tx_word = tx_data[ch_next];
        end else if (cfg.right_just) begin
            tx_word = {fill_bits, smp};
        end else begin
            tx_word = {smp, fill_bits};
        end
    end

    // A slave keeps its data pin off until a frame sync has placed its bit count.
    // Before that its slots are guesses, and it could clash with another talker.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slave_lock <= 1'b0;
        end else if (!run_slave) begin
            slave_lock <= 1'b0;
        end else if (fall_evt && pins_s.sync && !sync_prev) begin
            slave_lock <= 1'b1;
        end
    end

    // Data output changes on rise and lets go after the last fall.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
        end else if (!cfg.enable) begin
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
        end else if (rise_evt) begin
            o_dout_oe <= (|hit_next) & (run_master | slave_lock);
            if (cfg.lsb_first) begin
                o_dout <= tx_word[next_cnt[3:0]];
            end else begin
                o_dout <= tx_word[4'hf - next_cnt[3:0]];
            end
        end else if (fall_evt && bit_pos == 4'hf) begin
            o_dout_oe <= 1'b0;
        end
    end

    // Input bits are taken on the fall into their word position.
    always_comb begin
        next_shift = rx_shift;
        if (cfg.lsb_first) begin
            next_shift[bit_pos] = pins_s.din;
        end else begin
            next_shift[4'hf - bit_pos] = pins_s.din;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_shift <= '0;
        end else if (fall_evt && (|hit_cur)) begin
            rx_shift <= next_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, write commits with pready.
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
    assign rd_en = i_psel & i_penable & ~o_pready;

    // Read mux and address check.
    always_comb begin
        rd_data = '0;
        addr_ok = 1'b0;
        if (i_paddr == ADDR_CTRL) begin
            rd_data = {16'h0000, cfg};
            addr_ok = 1'b1;
        end
        if (i_paddr == ADDR_SLOT) begin
            for (int i = 0; i < NCH; i++) begin
                rd_data[i * SLOT_FIELD_STEP +: 5] = chmap[i];
            end
            addr_ok = 1'b1;
        end
        if (i_paddr == ADDR_STAT) begin
            rd_data = {5'h00, BUF_BYTES, frame_cnt};
            addr_ok = 1'b1;
        end
        for (int i = 0; i < NCH; i++) begin
            if (i_paddr == 8'(ADDR_TX0 + 8'(4 * i))) begin
                rd_data = {16'h0000, tx_data[i]};
                addr_ok = 1'b1;
            end
            if (i_paddr == 8'(ADDR_RX0 + 8'(4 * i))) begin
                rd_data = {16'h0000, rx_data[i]};
                addr_ok = 1'b1;
            end
        end
    end

    // Answer strobe, read data and error flag.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= rd_en;
            if (rd_en) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
                o_pslverr <= ~addr_ok;
            end else begin
                o_pslverr <= 1'b0;
            end
        end
    end

    // Register writes; reset leaves the default sample format.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg <= vssp_cfg_t'(CTRL_RESET);
            cfg_written <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                chmap[i] <= vssp_map_t'(MAP_RESET);
                tx_data[i] <= TX_RESET;
            end
        end else if (wr_en) begin
            if (i_paddr == ADDR_CTRL) begin
                cfg <= vssp_cfg_t'(i_pwdata[15:0]);
                cfg_written <= 1'b1;
            end
            for (int i = 0; i < NCH; i++) begin
                if (i_paddr == ADDR_SLOT) begin
                    chmap[i] <= vssp_map_t'(i_pwdata[i * SLOT_FIELD_STEP +: 5]);
                end
                if (i_paddr == 8'(ADDR_TX0 + 8'(4 * i))) begin
                    tx_data[i] <= i_pwdata[15:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_rise_hit;
        rise_evt && cfg.enable && (|hit_next) && (run_master || slave_lock);
    endsequence

    sequence s_last_fall;
        fall_evt && cfg.enable && bit_pos == 4'hf;
    endsequence

    a_master_pin_drive: assert property (##1 $past(run_master) |-> o_bclk_oe && o_sync_oe)
        else $error("master does not drive clock and sync");
    a_slave_pin_idle: assert property ($past(run_slave) |-> !o_bclk_oe && !o_sync_oe)
        else $error("slave drives clock or sync");
    a_dout_on_hit: assert property (s_rise_hit |=> o_dout_oe)
        else $error("assigned slot not driven");
    a_dout_off_free: assert property (rise_evt && cfg.enable && !(|hit_next) |=> !o_dout_oe)
        else $error("unassigned slot driven");
    a_dout_before_lock: assert property (rise_evt && run_slave && !slave_lock |=> !o_dout_oe)
        else $error("slave drove data before frame sync");
    a_dout_release: assert property (s_last_fall |=> !o_dout_oe)
        else $error("output not released after last bit");
    a_dout_on_rise: assert property ($changed(o_dout) && cfg.enable |-> $past(rise_evt))
        else $error("data changed off a rising edge");
    a_short_sync_bit: assert property (run_master && !cfg.long_sync && o_sync |-> bit_cnt == frame_last)
        else $error("short sync outside last bit");
    a_long_sync_bits: assert property (run_master && cfg.long_sync && o_sync |-> bit_cnt < 9'h003)
        else $error("long sync too wide");
    a_slot_count_8k: assert property (cfg.fs == FS_8K |-> frame_bits == (10'h010 << cfg.rate_sel))
        else $error("8 kHz frame size wrong");
    a_slot_count_16k: assert property (cfg.fs == FS_16K |-> frame_bits == (10'h008 << cfg.rate_sel))
        else $error("16 kHz frame size wrong");
    a_slave_short_align: assert property (fall_evt && run_slave && !cfg.long_sync && pins_s.sync && !sync_prev
        |=> bit_cnt == frame_last)
        else $error("slave short sync not aligned");
    a_reset_format: assert property (!cfg_written |-> !cfg.right_just && !cfg.lsb_first && !cfg.full16)
        else $error("default format lost");
endmodule

/* verif/vssp_codec_model.sv */
// Purpose: Behavioural codec that acts as slot master of the voice link.
// Assumes: Bit period 400 ns, NB bits per frame, channel data in slot 1.
// Notes: Port output is sampled at the fall, once it has settled from the rise.
`timescale 1ns/1ns
////////////////////////////////////////
module vssp_codec_model #(
    parameter int NB = 32
) (
    input wire logic i_run,
    input wire logic i_long,
    input wire logic [15:0] i_tx,
    input wire logic i_dout,
    input wire logic i_dout_oe,
    output logic o_bclk,
    output logic o_sync,
    output logic o_din,
    output logic [15:0] o_rx,
    output logic o_stray
);
    // Bit index in the frame and the word being gathered.
    int b;
    logic [15:0] sh;
    // One bit per pass; the clock stands still while the link is idle.
    initial begin
        o_din = 0;
        o_rx = '0;
        forever begin
            if (!i_run) begin
                b = 0;
                o_bclk = 0;
                o_sync = 0;
                o_stray = 0;
                #100;
            end else begin
                o_bclk = 1;
                o_sync = i_long ? (b < 3) : (b == NB - 1);
                // Outside slot 1 the line toggles, so a stale value never matches.
                o_din = (b >= 16) ? i_tx[31 - b] : ~o_din;
                #200 o_bclk = 0;
                // Sample at the fall: the port lets go of its last bit soon after it.
                if (b >= 16) sh[31 - b] = i_dout_oe ? i_dout : 1'bx;
                o_stray = o_stray | (b < 16 && i_dout_oe);
                if (b == NB - 1) o_rx = sh;
                #200 b = (b + 1) % NB;
            end
        end
    end
endmodule

/* verif/vssp_core_bench.sv */
// Purpose: Self-checking bench of the voice slot serial port.
// Assumes: Codec model is slot master at 2.5 MHz bit clock.
// Notes: Random samples and formats come from a fixed seed.
`timescale 1ns/1ns
////////////////////////////////////////
module vssp_core_bench;
    import vssp_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e, bp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    vssp_pins_t pins;
    logic bclk_o, bclk_oe, sync_o, sync_oe, dout, dout_oe;
    logic run, lng, m_bclk, m_sync, m_din, stray;
    logic [15:0] mtx, mrx, w;
    int error_cnt = 0, check_count = 0, cyc = 0, n, nr;
    // Pins resolve from the drive enables.
    assign pins = {bclk_oe ? bclk_o : m_bclk, sync_oe ? sync_o : m_sync, m_din};
    vssp_core i_vssp_core (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pins(pins), .o_bclk(bclk_o), .o_bclk_oe(bclk_oe), .o_sync(sync_o),
        .o_sync_oe(sync_oe), .o_dout(dout), .o_dout_oe(dout_oe));
    vssp_codec_model #(.NB(32)) i_vssp_codec_model (.i_run(run), .i_long(lng), .i_tx(mtx),
        .i_dout(dout), .i_dout_oe(dout_oe), .o_bclk(m_bclk), .o_sync(m_sync), .o_din(m_din),
        .o_rx(mrx), .o_stray(stray));
    ////////////////////////////////////////
    // Slot word as it should leave the port, in wire order.
    function automatic logic [15:0] slot_word(logic [12:0] s, logic [1:0] f, logic [2:0] v, logic rj, logic lf);
        logic [2:0] p;
        logic [15:0] x;
        p = (f == 0) ? 3'h0 : (f == 1) ? 3'h7 : (f == 2) ? {3{s[12]}} : v;
        x = rj ? {p, s} : {s, p};
        return lf ? {<<{x}} : x;
    endfunction
    // Received register: 16-bit word holding the sign-extended sample, upper half zero.
    function automatic logic [31:0] rx_exp(logic [15:0] x, logic rj, logic lf);
        logic [12:0] s;
        x = lf ? {<<{x}} : x;
        s = rj ? x[12:0] : x[15:3];
        return {16'h0000, {3{s[12]}}, s};
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (ex !== got) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) error_cnt++;
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(0, a, 0);
        chk("register", ex, r);
    endtask
    // Count clocks until the frame sync reaches a level, bounded.
    task automatic wait_sync(input logic lv);
        int t;
        t = 0;
        while (sync_o !== lv && t < 6000) begin
            @(posedge clk);
            t++;
            n++;
            nr = nr + int'(bclk_o & ~bp);
            bp = bclk_o;
        end
        if (t >= 6000) error_cnt++;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // A hang ends the run as a mismatch.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, run, lng, mtx} = '0;
        void'($urandom(32'hcab3));
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_STAT, {5'h00, BUF_BYTES, 16'h0000});
        apb(1, ADDR_RX0, 32'h0000_ffff);
        rd(ADDR_RX0, 32'h0000_0000);
        apb(0, 8'h24, 0);
        chk("unmapped error", 32'h0000_0001, {31'h0, e});
        for (int i = 0; i < 3; i++) begin
            w = 16'($urandom);
            apb(1, ADDR_TX0 + 8'(4 * i), {16'h0000, w});
            rd(ADDR_TX0 + 8'(4 * i), {16'h0000, w});
        end
        $display("test registers done");
        // Every fill mode, short and long sync, random placement and order.
        for (int k = 0; k < 8; k++) begin
            logic [12:0] s;
            logic [2:0] v;
            logic rj, lf;
            s = 13'($urandom);
            v = 3'($urandom);
            rj = 1'($urandom);
            lf = 1'($urandom);
            w = 16'($urandom);
            lng <= k[2];
            apb(1, ADDR_SLOT, 32'h0000_0011);
            apb(1, ADDR_TX0, {19'h0, s});
            apb(1, ADDR_CTRL, {16'h0, v, 2'(k), 1'b0, lf, rj, 3'h1, 2'h0, k[2], 1'b0, 1'b1});
            mtx <= w;
            run <= 1;
            repeat (1100) @(posedge clk);
            chk("slot word", {16'h0, slot_word(s, 2'(k), v, rj, lf)}, {16'h0, mrx});
            chk("idle slot drive", 0, {31'h0, stray});
            rd(ADDR_RX0, rx_exp(w, rj, lf));
            run <= 0;
            apb(1, ADDR_CTRL, 0);
        end
        $display("test link slave done");
        // Master at 128 kHz, one slot: frame of 16 bits is 2500 clocks.
        apb(1, ADDR_CTRL, 32'h0000_0003);
        wait_sync(1);
        n = 0;
        nr = 0;
        bp = bclk_o;
        wait_sync(0);
        wait_sync(1);
        chk("frame clocks", 1, {31'h0, n > 2498 && n < 2502});
        chk("bit clocks", 16, nr);
        n = 0;
        wait_sync(0);
        chk("sync width", 1, {31'h0, n > 154 && n < 159});
        chk("master drives", 3'b110, {29'h0, bclk_oe, sync_oe, dout_oe});
        // Master, long sync at 16 kHz and 256 kHz: 16-bit frame of 1250 clocks.
        apb(1, ADDR_CTRL, 32'h0000_002f);
        wait_sync(1);
        wait_sync(0);
        wait_sync(1);
        n = 0;
        wait_sync(0);
        chk("long sync width", 1, {31'h0, n > 232 && n < 237});
        wait_sync(1);
        chk("16k frame clocks", 1, {31'h0, n > 1248 && n < 1252});
        $display("test link master done");
        give_verdict();
    end
endmodule
